// ### rtl/t1_rai_pkg.sv
// Types shared by the RAI generator and its users
package t1_rai_pkg;
  // Insertion controls handed to the transmit framer datapath
  typedef struct packed {
    logic ds0_bit2_zero;
    logic y_bit_zero;
    logic fs12_one;
    logic dl_override;
    logic dl_bit;
  } rai_insert_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GUARD} rai_state_t;
endpackage : t1_rai_pkg

// ### rtl/t1_rai_regs.svh
// Register map, field positions, reset values and timing counts of the RAI generator
`ifndef T1_RAI_REGS_SVH
`define T1_RAI_REGS_SVH
`define ALARM_GEN_CTRL_OFS 32'h0000_0108
`define FRAMING_CTRL_OFS 32'h0000_010c
`define RAI_STATUS_OFS 32'h0000_0110
`define AGC_RESET 8'h00
`define FRM_RESET 2'h0
`define AGC_ONE_SEC_BIT 7
`define AGC_DUR_BIT 6
`define AGC_FMT_HI 5
`define AGC_FMT_LO 4
`define FMT_OFF 2'h0
`define FMT_STD 2'h1
`define FMT_J1 2'h2
`define FMT_ONES 2'h3
`define FRM_SF 2'h0
`define FRM_N 2'h1
`define FRM_T1DM 2'h2
`define FRM_ESF 2'h3
`define ST_SEND_BIT 0
`define ST_GUARD_BIT 1
`define ST_CNT_LO 8
`define PAT_LEN 16
`define RAI_PATTERNS 255
`define DL_RATE_BPS 4000
`define GUARD_TIME_MS 1000
`define GUARD_DL_BITS (`DL_RATE_BPS * `GUARD_TIME_MS / 1000)
`endif

// ### rtl/t1_yellow_alarm_generator.sv
// Transmit yellow alarm (RAI) generator with a classic Wishbone register slave
`timescale 1ns/100ps
`include "t1_rai_regs.svh"
module t1_yellow_alarm_generator #(
  parameter int PAT_COUNT = `RAI_PATTERNS,
  parameter int GUARD_BITS = `GUARD_DL_BITS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dl_slot_i,
  output t1_rai_pkg::rai_insert_t rai_o
);
  import t1_rai_pkg::*;

  localparam logic [7:0] PAT_LAST = 8'(PAT_COUNT);
  localparam logic [11:0] GUARD_LAST = 12'(GUARD_BITS - 1);

  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] agc_q, agc_d;
  logic [1:0] frm_q, frm_d;
  rai_state_t state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] pat_q, pat_d;
  logic [11:0] guard_q, guard_d;
  logic level_q, level_d;
  logic ones_q, ones_d;
  logic cont_q, cont_d;
  rai_insert_t out_q, out_d;
  logic keep, cont, ones, offered, wr_en;

  logic one_sec, cont_mode, bounded, level, rise, esf, active, boundary;
  logic [1:0] fmt;
  logic bus_req;

  // Field decode and choice of the duration control bit
  assign one_sec = agc_q[`AGC_ONE_SEC_BIT];
  assign fmt = agc_q[`AGC_FMT_HI:`AGC_FMT_LO];
  assign esf = (frm_q == `FRM_ESF);
  assign cont_mode = (fmt == `FMT_J1);
  assign bounded = (fmt == `FMT_STD) || (fmt == `FMT_ONES);
  // Rule off: code 10 follows its upper bit, 01 and 11 their lower bit
  assign level = one_sec ? agc_q[`AGC_DUR_BIT] :
                 (cont_mode ? agc_q[`AGC_FMT_HI] : agc_q[`AGC_FMT_LO]);
  assign rise = level & ~level_q;
  assign active = esf && (fmt != `FMT_OFF);
  // With the rule off the format bits double as the pulse, so code 00 during
  // an alarm only marks the end of the pulse; the pattern kind seen last stays
  assign keep = esf && (fmt != `FMT_OFF || !one_sec);
  assign cont = (fmt == `FMT_OFF) ? cont_q : cont_mode;
  assign ones = (fmt == `FMT_OFF) ? ones_q : (fmt == `FMT_ONES);
  // A slot counts only when its bit really stood on the line; otherwise the
  // first bit of an alarm could be consumed before the override is shown
  assign offered = dl_slot_i && out_q.dl_override;
  assign boundary = offered && (bit_q == 4'(`PAT_LEN - 1));
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  // Writes land at the edge where the master samples ack
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

  // Wishbone slave: one wait state, unmapped reads give zero and writes drop
  always_comb begin
    ack_d = bus_req;
    rdat_d = 32'h0000_0000;
    agc_d = agc_q;
    frm_d = frm_q;
    if (bus_req) begin
      case (wb_adr_i)
        `ALARM_GEN_CTRL_OFS: begin
          rdat_d = {24'h00_0000, agc_q};
        end
        `FRAMING_CTRL_OFS: begin
          rdat_d = {30'h0000_0000, frm_q};
        end
        `RAI_STATUS_OFS: begin
          rdat_d[`ST_SEND_BIT] = (state_q == ST_SEND);
          rdat_d[`ST_GUARD_BIT] = (state_q == ST_GUARD);
          rdat_d[`ST_CNT_LO +: 8] = pat_q;
        end
        default: begin
          rdat_d = 32'h0000_0000;
        end
      endcase
    end
    // Unmapped writes are acked and dropped
    if (wr_en) begin
      if (wb_adr_i == `ALARM_GEN_CTRL_OFS) begin
        agc_d = wb_dat_i[7:0];
      end else if (wb_adr_i == `FRAMING_CTRL_OFS) begin
        frm_d = wb_dat_i[1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      agc_q <= `AGC_RESET;
      frm_q <= `FRM_RESET;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      agc_q <= agc_d;
      frm_q <= frm_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ESF data link engine; RAI only ends on a pattern boundary so the far
  // end never sees a torn pattern, except when the code or framing drops it
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    pat_d = pat_q;
    guard_d = guard_q;
    level_d = level;
    ones_d = ones;
    cont_d = cont;
    case (state_q)
      ST_IDLE: begin
        bit_d = 4'h0;
        pat_d = 8'h00;
        if (active && level) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (offered) begin
          bit_d = bit_q + 4'h1;
        end
        if (boundary && pat_q != PAT_LAST) begin
          pat_d = pat_q + 8'h01;
        end
        if (!cont && rise) begin
          pat_d = 8'h00;
        end
        if (!keep) begin
          state_d = one_sec ? ST_GUARD : ST_IDLE;
        end else if (boundary && !level) begin
          if (cont || (!rise && pat_q >= PAT_LAST - 8'h01)) begin
            state_d = one_sec ? ST_GUARD : ST_IDLE;
          end
        end
        guard_d = GUARD_LAST;
      end
      ST_GUARD: begin
        // New alarms are held off here; a pulse that falls inside is lost
        if (!one_sec) begin
          state_d = ST_IDLE;
        end else if (dl_slot_i) begin
          if (guard_q == 12'h000) begin
            state_d = ST_IDLE;
          end else begin
            guard_d = guard_q - 12'h001;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      pat_q <= 8'h00;
      guard_q <= 12'h000;
      level_q <= 1'b0;
      ones_q <= 1'b0;
      cont_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      pat_q <= pat_d;
      guard_q <= guard_d;
      level_q <= level_d;
      ones_q <= ones_d;
      cont_q <= cont_d;
    end
  end

  // Insertion controls, registered so the datapath sees clean levels
  always_comb begin
    out_d = '0;
    case (frm_q)
      `FRM_SF, `FRM_N: begin
        out_d.ds0_bit2_zero = bounded;
        out_d.fs12_one = (frm_q == `FRM_SF) && cont_mode;
      end
      `FRM_T1DM: begin
        out_d.y_bit_zero = (fmt != `FMT_OFF);
      end
      default: begin
        out_d.dl_override = (state_q == ST_SEND) && keep;
        // Eight ones then eight zeros, or sixteen ones for code 11
        out_d.dl_bit = out_d.dl_override && (!bit_q[3] || ones);
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign rai_o = out_q;

  // Format and insertion checks
  a_code_off_silent: assert property (@(posedge clk_i) disable iff (rst_i)
    (fmt == `FMT_OFF && (one_sec || state_q != ST_SEND)) |=> (rai_o == '0))
    else $error("RAI sent with format code off");
  a_ds0_bit_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (bounded && (frm_q == `FRM_SF || frm_q == `FRM_N)) |=> rai_o.ds0_bit2_zero)
    else $error("DS0 bit 2 not forced in SF or N");
  a_ybit_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (frm_q == `FRM_T1DM && fmt != `FMT_OFF) |=> (rai_o.y_bit_zero && !rai_o.ds0_bit2_zero))
    else $error("Y bit not driven in T1DM");
  a_fs12_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (frm_q == `FRM_SF && cont_mode) |=> (rai_o.fs12_one && !rai_o.ds0_bit2_zero))
    else $error("Fs of frame 12 not set");
  a_half_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_SEND && esf && fmt == `FMT_STD && bit_q[3]) |=> !rai_o.dl_bit)
    else $error("Second half of pattern not zero");
  a_all_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_SEND && esf && fmt == `FMT_ONES) |=> (rai_o.dl_bit && rai_o.dl_override))
    else $error("Sixteen-ones pattern broken");
  a_min_length: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_SEND && keep && !cont && pat_q < PAT_LAST - 8'h01) |=> state_q == ST_SEND)
    else $error("RAI ended before 255 patterns");
  a_hold_long: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_SEND && keep && level) |=> state_q == ST_SEND)
    else $error("RAI ended while enable held");
  a_retrigger_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_SEND && !cont && rise) |=> pat_q == 8'h00)
    else $error("Pattern count not cleared on new pulse");
  a_guard_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_SEND && one_sec ##1 state_q != ST_SEND) |-> state_q == ST_GUARD)
    else $error("No guard after RAI with rule on");
  a_follow_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_IDLE && active && level) |=> state_q == ST_SEND ##1 rai_o.dl_override)
    else $error("RAI did not start on held control bit");
  a_rule_select: assert property (@(posedge clk_i) disable iff (rst_i)
    (!one_sec && bounded) |-> (level == agc_q[`AGC_FMT_LO]))
    else $error("Wrong duration bit with rule off");
  // Engine bookkeeping: continuous runs, guard, counters
  a_cont_until_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_SEND && keep && cont && !boundary) |=> state_q == ST_SEND)
    else $error("Continuous RAI ended off a pattern boundary");
  a_guard_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_GUARD && one_sec) |=> state_q != ST_SEND)
    else $error("RAI restarted inside the guard time");
  a_no_guard_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (!one_sec && state_q == ST_SEND) |=> state_q != ST_GUARD)
    else $error("Guard entered with rule off");
  a_count_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    pat_q <= PAT_LAST)
    else $error("Pattern count beyond its limit");
  a_slot_unseen: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_SEND && dl_slot_i && !out_q.dl_override) |=> $stable(bit_q))
    else $error("Bit index moved on a slot with no bit shown");
  a_idle_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_IDLE) |=> (bit_q == 4'h0 && pat_q == 8'h00))
    else $error("Counters not cleared while idle");
  a_dl_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (!esf) |=> !rai_o.dl_override)
    else $error("Data link overridden outside ESF");
  // Register bus: single-cycle ack, write taken at the ack edge
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack stood for more than one cycle");
  a_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_adr_i == `ALARM_GEN_CTRL_OFS) |=>
      ({24'h00_0000, agc_q} == ($past(wb_dat_i) & 32'h0000_00ff)))
    else $error("Control write did not land");
endmodule : t1_yellow_alarm_generator

// ### test/dl_far_end.sv
// Far-end terminal model: data link slot timing and capture of sent RAI bits
`timescale 1ns/100ps
module dl_far_end (
  input wire logic clk_i,
  input wire logic rst_i,
  input t1_rai_pkg::rai_insert_t rai_i,
  output logic dl_slot_o,
  output int n_bits_o,
  output logic [15:0] sh_o
);
  import t1_rai_pkg::*;
  logic [1:0] div_q;
  // Slot every fourth cycle, well above the two-cycle minimum spacing
  assign dl_slot_o = (div_q == 2'h3);
  // Bits are taken at the slot edge, as the line would send them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 2'h0;
      n_bits_o <= 0;
      sh_o <= 16'h0000;
    end else begin
      div_q <= div_q + 2'h1;
      if (dl_slot_o && rai_i.dl_override) begin
        n_bits_o <= n_bits_o + 1;
        sh_o <= {sh_o[14:0], rai_i.dl_bit};
      end
    end
  end
endmodule : dl_far_end

// ### test/tb_top.sv
// Self-checking bench for the yellow alarm generator
`timescale 1ns/100ps
`include "t1_rai_regs.svh"
module tb_top;
  import t1_rai_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, dat = 0, rd, wb_dat_o, v;
  logic wb_ack_o, dl_slot;
  rai_insert_t rai_o;
  int n_fail = 0, num_checks = 0, seed = 32'h85e9, n_bits, got;
  logic [15:0] sh;
  always #10 clk_i = ~clk_i;
  t1_yellow_alarm_generator #(.PAT_COUNT(3), .GUARD_BITS(8)) i_t1_yellow_alarm_generator (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dl_slot_i(dl_slot), .rai_o(rai_o));
  dl_far_end i_dl_far_end (.clk_i(clk_i), .rst_i(rst_i), .rai_i(rai_o),
    .dl_slot_o(dl_slot), .n_bits_o(n_bits), .sh_o(sh));
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Classic cycle: hold until ack is sampled, then one idle cycle
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    cyc <= 0; stb <= 0;
    @(posedge clk_i);
  endtask : wb
  function automatic logic [2:0] fmt_exp(input int f, input int c);
    return {f < 2 && (c == 1 || c == 3), f == 2 && c != 0, f == 0 && c == 2};
  endfunction : fmt_exp
  // Pulse the control, then wait for the alarm to end; guard gap first
  task esf(input logic [7:0] on, input logic [7:0] off, input int hold, input logic [15:0] p);
    int n0, i;
    repeat (40) @(posedge clk_i);
    n0 = n_bits;
    wb(1, `ALARM_GEN_CTRL_OFS, on);
    repeat (hold) @(posedge clk_i);
    wb(1, `ALARM_GEN_CTRL_OFS, off);
    i = 0;
    while (rai_o.dl_override === 1'b1 && i < 5000) begin
      @(posedge clk_i);
      i++;
    end
    got = n_bits - n0;
    chk(sh, p);
  endtask : esf
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, `ALARM_GEN_CTRL_OFS, 0); chk(rd, `AGC_RESET);
    wb(1, 32'h0000_0200, 32'h0000_00ff); wb(0, 32'h0000_0200, 0); chk(rd, 0);
    // Non-ESF formats under every code, random rule bit and spare bits
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 4; c++) begin
        got = $random(seed);
        v = {24'h0, got[7], 1'b0, c[1:0], got[3:0]};
        wb(1, `FRAMING_CTRL_OFS, f);
        wb(1, `ALARM_GEN_CTRL_OFS, v);
        wb(0, `ALARM_GEN_CTRL_OFS, 0); chk(rd, v);
        chk({rai_o.ds0_bit2_zero, rai_o.y_bit_zero, rai_o.fs12_one}, fmt_exp(f, c));
      end
    end
    wb(1, `FRAMING_CTRL_OFS, `FRM_ESF);
    wb(1, `ALARM_GEN_CTRL_OFS, 0);
    esf(8'hd0, 8'h90, 4, 16'hff00); chk(got, 48);
    wb(0, `RAI_STATUS_OFS, 0); chk(rd[15:8], 3);
    chk(rd[1], 1);
    repeat (40) @(posedge clk_i);
    wb(0, `RAI_STATUS_OFS, 0); chk(rd[1], 0);
    esf(8'hd0, 8'h90, 320, 16'hff00); chk(got % 16, 0);
    chk(got > 64, 1);
    esf(8'hf0, 8'hb0, 4, 16'hffff); chk(got, 48);
    // Rule off: the format bits are the pulse and no guard follows; last, code 10 with the rule on
    esf(8'h10, 8'h00, 4, 16'hff00); chk(got, 48);
    esf(8'h30, 8'h00, 4, 16'hffff); chk(got, 48);
    esf(8'h20, 8'h00, 100, 16'hff00); chk(got % 16, 0);
    chk(got > 0, 1);
    esf(8'he0, 8'ha0, 100, 16'hff00); chk(got % 16, 0);
    chk(got > 0, 1);
    give_verdict;
  end
endmodule : tb_top
